// ---- hw/harvard_alu.sv ----
`timescale 1ns/1ps
module harvard_alu
	import harvard_core_pkg::*;
(
	input  alu_op_t    i_op,     // Operation
	input  wire  [7:0] i_a,      // Working accumulator
	input  wire  [7:0] i_b,      // File register or literal
	input  wire        i_cin,    // Carry in for rotates
	output logic [7:0] o_res,    // Result
	output logic       o_c,      // Carry or inverted borrow
	output logic       o_dc,     // Nibble carry
	output logic       o_z,      // Result is zero
	output logic       o_upd_c,  // Carry flag affected
	output logic       o_upd_dc, // Nibble carry affected
	output logic       o_upd_z   // Zero flag affected
);
	// Sum with carry-in, one bit wider than its operands
	function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y, input logic ci);
		add9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
	endfunction : add9

	logic [8:0] s_full;
	logic [8:0] s_nib;

	// Subtraction is b plus inverted a plus one, so carry out is the inverted borrow
	always_comb
	begin
		s_full   = 9'h000;
		s_nib    = 9'h000;
		o_res    = 8'h00;
		o_c      = 1'b0;
		o_dc     = 1'b0;
		o_upd_c  = 1'b0;
		o_upd_dc = 1'b0;
		o_upd_z  = 1'b1;
		case (i_op)
			ALU_ADD, ALU_SUB:
			begin
				s_full   = (i_op == ALU_ADD) ? add9(i_a, i_b, 1'b0) : add9(~i_a, i_b, 1'b1);
				s_nib    = (i_op == ALU_ADD) ? add9({4'h0, i_a[3:0]}, {4'h0, i_b[3:0]}, 1'b0)
					: add9({4'h0, ~i_a[3:0]}, {4'h0, i_b[3:0]}, 1'b1);
				o_res    = s_full[7:0];
				o_c      = s_full[8];
				o_dc     = s_nib[4];
				o_upd_c  = 1'b1;
				o_upd_dc = 1'b1;
			end
			ALU_AND:  o_res = i_a & i_b;
			ALU_IOR:  o_res = i_a | i_b;
			ALU_XOR:  o_res = i_a ^ i_b;
			ALU_COM:  o_res = ~i_b;
			ALU_INC:  o_res = i_b + 8'h01;
			ALU_DEC:  o_res = i_b - 8'h01;
			ALU_CLR:  o_res = 8'h00;
			ALU_PASS_A:
			begin
				o_res   = i_a;
				o_upd_z = 1'b0;
			end
			ALU_PASS_B: o_res = i_b;
			ALU_RR, ALU_RL:
			begin
				o_res   = (i_op == ALU_RR) ? {i_cin, i_b[7:1]} : {i_b[6:0], i_cin};
				o_c     = (i_op == ALU_RR) ? i_b[0] : i_b[7];
				o_upd_c = 1'b1;
				o_upd_z = 1'b0;
			end
			ALU_SWAP:
			begin
				o_res   = {i_b[3:0], i_b[7:4]};
				o_upd_z = 1'b0;
			end
			default: o_upd_z = 1'b0;
		endcase
		o_z = (o_res == 8'h00);
	end
endmodule : harvard_alu

// ---- hw/harvard_core.sv ----
`timescale 1ns/1ps
// How it works
// - Program memory and data memory each have their own separate bus.
// - Instructions are single 14-bit words, one fetched per instruction cycle.
// - Next instruction is fetched while the current one executes.
// - Non-branch instructions take one 500 ns cycle; branches take two.
// - Program space is 4K by 14; data space holds 176 general bytes.
// - Special registers, program counter included, sit in data address space.
// - File registers are reached directly or indirectly through the pointer.
// - Every operation works on any register with any addressing mode.
// - ALU is 8 bits: add, subtract, shift and logic.
// - Arithmetic treats operands and results as two's complement.
// - Two-operand ops use the accumulator plus a file register or literal.
// - Single-operand ops use the accumulator or a file register.
// - Working accumulator is 8 bits and has no data address.
// - ALU updates carry, nibble carry and zero flags per instruction.
// - Subtraction carry and nibble carry hold inverted borrow.
module harvard_core
	import harvard_core_pkg::*;
#(
	parameter int CYCLE_CLKS = INSTR_CLKS // Clocks per instruction cycle
)(
	input  wire  logic                I_CLK_SYS,     // System clock
	input  wire  logic                I_RST_N,       // Synchronous reset, active low
	output logic [PROG_AW-1:0]        O_PROG_ADDR,   // Program memory address
	input  wire  logic [INSN_W-1:0]   I_PROG_DATA,   // Program memory word
	output logic [DATA_AW-1:0]        O_DATA_RADDR,  // Data memory read address
	input  wire  logic [DATA_W-1:0]   I_DATA_RDATA,  // Data memory read data
	output logic [DATA_AW-1:0]        O_DATA_WADDR,  // Data memory write address
	output logic [DATA_W-1:0]         O_DATA_WDATA,  // Data memory write data
	output logic                      O_DATA_WE,     // Data memory write strobe
	output logic [DATA_W-1:0]         O_W,           // Working accumulator
	output logic [DATA_W-1:0]         O_STATUS       // Status register
);
	if (CYCLE_CLKS < 1 || CYCLE_CLKS > (1 << CNT_W))
		$error("CYCLE_CLKS out of range");
	if ((1 << PROG_AW) < PROG_WORDS)
		$error("Program address too narrow");

	typedef struct packed {
		logic [PROG_AW-1:0] pc;
		logic [INSN_W-1:0]  ir;
		logic               ir_valid;
		logic [DATA_W-1:0]  w;
		logic [DATA_W-1:0]  status;
		logic [DATA_W-1:0]  fsr;
		logic [DATA_AW-1:0] raddr;
		logic [DATA_AW-1:0] waddr;
		logic [DATA_W-1:0]  wdata;
		logic               we;
		logic [CNT_W-1:0]   cnt;
	} core_state_t;

	core_state_t q_reg;
	core_state_t q_next;

	// Resolve the operand address at fetch so it leaves a flip-flop
	function automatic logic [DATA_AW-1:0] file_addr(input logic [INSN_W-1:0] insn,
		input logic [DATA_W-1:0] fsr, input logic rp0);
		file_addr = (insn[F_W-1:0] == ADDR_INDF) ? fsr : {rp0, insn[F_W-1:0]};
	endfunction : file_addr

	logic              tick;
	logic [1:0]        cls;
	logic [3:0]        op;
	logic              dest_f;
	logic [DATA_W-1:0] fval;
	logic [DATA_W-1:0] opb;
	logic              is_lit;
	alu_op_t           alu_op;
	logic              writes;
	logic              dest_w;
	logic              ext_wr;
	logic              flush;
	logic [7:0]        alu_res;
	logic              alu_c;
	logic              alu_dc;
	logic              alu_z;
	logic              upd_c;
	logic              upd_dc;
	logic              upd_z;
	logic [8:0]        sum9;
	logic [4:0]        nib5;

	// Instruction cycle boundary; all architectural state moves only here
	assign tick   = (q_reg.cnt == CNT_W'(CYCLE_CLKS - 1));
	assign cls    = q_reg.ir[CLS_HI:CLS_LO];
	assign op     = q_reg.ir[OP_HI:OP_LO];
	assign dest_f = q_reg.ir[D_BIT];
	assign is_lit = (cls == CLS_LIT);

	// File read: internal special registers first, else forwarded or external data
	always_comb
	begin
		case (q_reg.raddr[F_W-1:0])
			ADDR_STATUS: fval = q_reg.status;
			ADDR_FSR:    fval = q_reg.fsr;
			ADDR_PCL:    fval = q_reg.pc[DATA_W-1:0] - 8'h01;
			ADDR_INDF:   fval = 8'h00; // Pointer aimed at itself reads zero
			default:     fval = (q_reg.we && q_reg.waddr == q_reg.raddr) ? q_reg.wdata : I_DATA_RDATA;
		endcase
		opb = is_lit ? q_reg.ir[LIT_W-1:0] : fval;
	end

	// Decode into an ALU operation and a destination
	always_comb
	begin
		alu_op = ALU_PASS_B;
		writes = q_reg.ir_valid;
		dest_w = 1'b0;
		if (cls == CLS_BYTE)
		begin
			dest_w = !dest_f;
			case (op)
				OP_MOVWF:
				begin
					alu_op = ALU_PASS_A;
					writes = q_reg.ir_valid && dest_f; // Clear d is the no-op
				end
				OP_CLR:   alu_op = ALU_CLR;
				OP_SUBWF: alu_op = ALU_SUB;
				OP_DECF:  alu_op = ALU_DEC;
				OP_IORWF: alu_op = ALU_IOR;
				OP_ANDWF: alu_op = ALU_AND;
				OP_XORWF: alu_op = ALU_XOR;
				OP_ADDWF: alu_op = ALU_ADD;
				OP_MOVF:  alu_op = ALU_PASS_B;
				OP_COMF:  alu_op = ALU_COM;
				OP_INCF:  alu_op = ALU_INC;
				OP_RRF:   alu_op = ALU_RR;
				OP_RLF:   alu_op = ALU_RL;
				OP_SWAPF: alu_op = ALU_SWAP;
				default:  writes = 1'b0;
			endcase
		end
		else if (is_lit)
		begin
			dest_w = 1'b1;
			case (op)
				OP_IORLW: alu_op = ALU_IOR;
				OP_ANDLW: alu_op = ALU_AND;
				OP_XORLW: alu_op = ALU_XOR;
				OP_SUBLW, OP_SUBLW + 4'h1: alu_op = ALU_SUB;
				OP_ADDLW, OP_ADDLW + 4'h1: alu_op = ALU_ADD;
				default:  alu_op = (op[3:2] == OP_MOVLW[3:2]) ? ALU_PASS_B : ALU_PASS_A;
			endcase
		end
		else
			writes = 1'b0;
	end

	harvard_alu u_alu (
		.i_op     (alu_op),
		.i_a      (q_reg.w),
		.i_b      (opb),
		.i_cin    (q_reg.status[ST_C]),
		.o_res    (alu_res),
		.o_c      (alu_c),
		.o_dc     (alu_dc),
		.o_z      (alu_z),
		.o_upd_c  (upd_c),
		.o_upd_dc (upd_dc),
		.o_upd_z  (upd_z)
	);

	// Reference sums kept only for the checks below
	assign sum9 = {1'b0, q_reg.w} + {1'b0, opb};
	assign nib5 = {1'b0, q_reg.w[3:0]} + {1'b0, opb[3:0]};

	// Execute, write back, then fetch; a taken branch drops the word already fetched
	always_comb
	begin
		q_next    = q_reg;
		q_next.we = 1'b0;
		q_next.cnt = tick ? '0 : q_reg.cnt + CNT_W'(1);
		ext_wr    = 1'b0;
		flush     = 1'b0;
		if (tick)
		begin
			if (writes && dest_w)
				q_next.w = alu_res;
			else if (writes)
			begin
				case (q_reg.raddr[F_W-1:0])
					ADDR_STATUS: q_next.status = alu_res;
					ADDR_FSR:    q_next.fsr = alu_res;
					ADDR_PCL:
					begin
						q_next.pc = {q_reg.pc[PROG_AW-1:DATA_W], alu_res};
						flush     = 1'b1;
					end
					ADDR_INDF:   ext_wr = 1'b0;
					default:     ext_wr = 1'b1;
				endcase
			end
			if (q_reg.ir_valid && writes)
			begin
				if (upd_c)
					q_next.status[ST_C] = alu_c;
				if (upd_dc)
					q_next.status[ST_DC] = alu_dc;
				if (upd_z)
					q_next.status[ST_Z] = alu_z;
			end
			if (ext_wr)
			begin
				q_next.we    = 1'b1;
				q_next.waddr = q_reg.raddr;
				q_next.wdata = alu_res;
			end
			if (q_reg.ir_valid && cls == CLS_BRANCH)
			begin
				q_next.pc = {q_reg.pc[PROG_AW-1], q_reg.ir[JUMP_W-1:0]};
				flush     = 1'b1;
			end
			if (flush)
				q_next.ir_valid = 1'b0;
			else
			begin
				q_next.ir       = I_PROG_DATA;
				q_next.ir_valid = 1'b1;
				q_next.pc       = q_reg.pc + 12'h001;
				q_next.raddr    = file_addr(I_PROG_DATA, q_next.fsr, q_next.status[ST_RP0]);
			end
		end
	end

	// State register; reset starts with an empty pipeline
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
		begin
			q_reg        <= '0;
			q_reg.pc     <= RST_PC;
			q_reg.status <= RST_STATUS;
		end
		else
			q_reg <= q_next;
	end

	assign O_PROG_ADDR  = q_reg.pc;
	assign O_DATA_RADDR = q_reg.raddr;
	assign O_DATA_WADDR = q_reg.waddr;
	assign O_DATA_WDATA = q_reg.wdata;
	assign O_DATA_WE    = q_reg.we;
	assign O_W          = q_reg.w;
	assign O_STATUS     = q_reg.status;

	fetch_step_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && !flush) |=> (q_reg.ir == $past(I_PROG_DATA)) && (O_PROG_ADDR == $past(O_PROG_ADDR) + 12'h001))
		else $error("fetch did not advance");
	branch_bubble_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && flush) |=> !q_reg.ir_valid)
		else $error("branch did not insert a bubble");
	hold_between_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		!tick |=> $stable(O_PROG_ADDR) && $stable(O_W) && $stable(O_STATUS))
		else $error("state moved between instruction cycles");
	add_carry_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && q_reg.ir_valid && alu_op == ALU_ADD && writes) |=> O_STATUS[ST_C] == $past(sum9[8]))
		else $error("add carry wrong");
	sub_borrow_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && alu_op == ALU_SUB && writes) |=> O_STATUS[ST_C] == $past(opb >= q_reg.w))
		else $error("subtract borrow wrong");
	nibble_carry_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && alu_op == ALU_ADD && writes) |=> O_STATUS[ST_DC] == $past(nib5[4]))
		else $error("nibble carry wrong");
	zero_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && writes && upd_z) |=> O_STATUS[ST_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong");
	w_private_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		$changed(O_W) |-> $past(tick && writes && dest_w))
		else $error("accumulator changed without a write to it");
	indirect_addr_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && !flush && I_PROG_DATA[F_W-1:0] == ADDR_INDF) |=> O_DATA_RADDR == $past(q_next.fsr))
		else $error("indirect address not taken from pointer");
	// Strobe lasts one clock unless a one-clock cycle starts the next write right away
	data_write_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(tick && ext_wr) |=> O_DATA_WE && (O_DATA_WADDR == $past(q_reg.raddr))
		##1 (O_DATA_WE == $past(tick && ext_wr)))
		else $error("data write strobe wrong");
endmodule : harvard_core

// ---- pkg/harvard_core_pkg.sv ----
package harvard_core_pkg;
	// Instruction cycle timing: the least time rounds up to whole clocks
	localparam int T_INSTR_NS    = 500;
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSTR_CLKS    = (T_INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 4;

	// Bus widths and memory sizes
	localparam int INSN_W    = 14;
	localparam int PROG_AW   = 12;
	localparam int DATA_W    = 8;
	localparam int DATA_AW   = 8;
	localparam int PROG_WORDS = 4096;
	localparam int GP_BYTES  = 176;

	// Instruction word fields
	localparam int F_W     = 7;
	localparam int D_BIT   = 7;
	localparam int OP_HI   = 11;
	localparam int OP_LO   = 8;
	localparam int CLS_HI  = 13;
	localparam int CLS_LO  = 12;
	localparam int LIT_W   = 8;
	localparam int JUMP_W  = 11;

	// Instruction classes
	localparam logic [1:0] CLS_BYTE   = 2'h0;
	localparam logic [1:0] CLS_BRANCH = 2'h2;
	localparam logic [1:0] CLS_LIT    = 2'h3;

	// File-register operation codes
	localparam logic [3:0] OP_MOVWF = 4'h0;
	localparam logic [3:0] OP_CLR   = 4'h1;
	localparam logic [3:0] OP_SUBWF = 4'h2;
	localparam logic [3:0] OP_DECF  = 4'h3;
	localparam logic [3:0] OP_IORWF = 4'h4;
	localparam logic [3:0] OP_ANDWF = 4'h5;
	localparam logic [3:0] OP_XORWF = 4'h6;
	localparam logic [3:0] OP_ADDWF = 4'h7;
	localparam logic [3:0] OP_MOVF  = 4'h8;
	localparam logic [3:0] OP_COMF  = 4'h9;
	localparam logic [3:0] OP_INCF  = 4'ha;
	localparam logic [3:0] OP_RRF   = 4'hc;
	localparam logic [3:0] OP_RLF   = 4'hd;
	localparam logic [3:0] OP_SWAPF = 4'he;

	// Literal operation codes (upper bits of the op field)
	localparam logic [3:0] OP_MOVLW = 4'h0;
	localparam logic [3:0] OP_IORLW = 4'h8;
	localparam logic [3:0] OP_ANDLW = 4'h9;
	localparam logic [3:0] OP_XORLW = 4'ha;
	localparam logic [3:0] OP_SUBLW = 4'hc;
	localparam logic [3:0] OP_ADDLW = 4'he;

	// Internally held special registers, low seven address bits
	localparam logic [6:0] ADDR_INDF   = 7'h00;
	localparam logic [6:0] ADDR_PCL    = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_FSR    = 7'h04;

	// Status register bits
	localparam int ST_C   = 0;
	localparam int ST_DC  = 1;
	localparam int ST_Z   = 2;
	localparam int ST_RP0 = 5;

	// Reset values
	localparam logic [11:0] RST_PC     = 12'h000;
	localparam logic [7:0]  RST_STATUS = 8'h00;

	typedef enum {
		ALU_PASS_A, ALU_PASS_B, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR,
		ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP
	} alu_op_t;
endpackage : harvard_core_pkg

// ---- verif/harvard_mem_model.sv ----
`timescale 1ns/1ps
// Program store and data file on the far side of the two buses
module harvard_mem_model
	import harvard_core_pkg::*;
(
	input  wire logic               i_clk,   // System clock
	input  wire logic [PROG_AW-1:0] i_paddr, // Program address
	output logic      [INSN_W-1:0]  o_pdata, // Program word
	input  wire logic [DATA_AW-1:0] i_raddr, // Data read address
	output logic      [DATA_W-1:0]  o_rdata, // Data read byte
	input  wire logic [DATA_AW-1:0] i_waddr, // Data write address
	input  wire logic [DATA_W-1:0]  i_wdata, // Data write byte
	input  wire logic               i_we     // Data write strobe
);
	logic [INSN_W-1:0] rom [PROG_WORDS];
	logic [DATA_W-1:0] ram [2**DATA_AW];

	// Two independent ports, so a fetch never waits on a data access
	assign o_pdata = rom[i_paddr];
	assign o_rdata = ram[i_raddr];

	// Write lands on the edge that sees the strobe
	always @(posedge i_clk)
	begin
		if (i_we)
			ram[i_waddr] <= i_wdata;
	end
endmodule : harvard_mem_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import harvard_core_pkg::*;
	localparam int CYC = 2; // Two clocks per cycle keeps the run short yet shows holding
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic [PROG_AW-1:0] prog_addr;
	logic [INSN_W-1:0]  prog_data;
	logic [DATA_AW-1:0] raddr;
	logic [DATA_W-1:0]  rdata;
	logic [DATA_AW-1:0] waddr;
	logic [DATA_W-1:0]  wdata;
	logic               we;
	logic [DATA_W-1:0]  w;
	logic [DATA_W-1:0]  status;
	int                 err_total = 0;
	int                 cmp_count = 0;

	always #25 clk = ~clk;

	harvard_core #(.CYCLE_CLKS(CYC)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .O_PROG_ADDR(prog_addr),
		.I_PROG_DATA(prog_data), .O_DATA_RADDR(raddr), .I_DATA_RDATA(rdata), .O_DATA_WADDR(waddr),
		.O_DATA_WDATA(wdata), .O_DATA_WE(we), .O_W(w), .O_STATUS(status));
	harvard_mem_model mem (.i_clk(clk), .i_paddr(prog_addr), .o_pdata(prog_data), .i_raddr(raddr),
		.o_rdata(rdata), .i_waddr(waddr), .i_wdata(wdata), .i_we(we));

	// Instruction word builders
	function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
		return {CLS_LIT, op, k};
	endfunction : lit
	function automatic logic [13:0] fop(input logic [3:0] op, input logic d, input logic [6:0] f);
		return {CLS_BYTE, op, d, f};
	endfunction : fop
	function automatic logic [13:0] jmp(input logic [10:0] t);
		return {CLS_BRANCH, 1'b0, t};
	endfunction : jmp

	task report_and_stop;
		$display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	// Reset first; the edge that applies it also lands a pending write, so blank memories after it
	task hold;
		@(posedge clk);
		#1 rst_n = 1'b0;
		@(posedge clk);
		#1;
		for (int i = 0; i < PROG_WORDS; i++)
			mem.rom[i] = 14'h0000;
		for (int i = 0; i < (1 << DATA_AW); i++)
			mem.ram[i] = 8'h3c;
	endtask : hold

	task go(input int n);
		repeat (n) @(posedge clk);
		#1 rst_n = 1'b1;
	endtask : go

	// One instruction cycle, then accumulator and flags
	task step(input logic [7:0] ew, input logic [7:0] es);
		repeat (CYC) @(posedge clk);
		#2;
		chk(w, ew);
		chk(status, es);
	endtask : step

	// Clocks until the accumulator moves, bounded
	task wait_change(output int n);
		logic [7:0] old;
		old = w;
		n = 0;
		while (w === old && n < 40)
		begin
			@(posedge clk);
			#2;
			n++;
		end
		if (n >= 40)
		begin
			err_total++;
			report_and_stop();
		end
	endtask : wait_change

	task arith_flags;
		hold();
		mem.rom[0] = lit(OP_MOVLW, 8'h0f);
		mem.rom[1] = lit(OP_ADDLW, 8'h01);
		mem.rom[2] = lit(OP_SUBLW, 8'h10);
		mem.rom[3] = lit(OP_ADDLW, 8'h01);
		mem.rom[4] = lit(OP_SUBLW, 8'h00);
		mem.rom[5] = lit(OP_ADDLW, 8'h81);
		go(20);
		repeat (CYC) @(posedge clk);
		step(8'h0f, 8'h00);
		step(8'h10, 8'h02);
		step(8'h00, 8'h07);
		step(8'h01, 8'h00);
		step(8'hff, 8'h00);
		step(8'h80, 8'h03);
	endtask : arith_flags

	task file_ops;
		hold();
		mem.rom[0] = lit(OP_MOVLW, 8'h55);
		mem.rom[1] = fop(OP_MOVWF, 1'b1, 7'h20);
		mem.rom[2] = lit(OP_MOVLW, 8'h21);
		mem.rom[3] = fop(OP_MOVWF, 1'b1, ADDR_FSR);
		mem.rom[4] = lit(OP_MOVLW, 8'haa);
		mem.rom[5] = fop(OP_MOVWF, 1'b1, ADDR_INDF);
		mem.rom[6] = fop(OP_ADDWF, 1'b0, 7'h20);
		mem.rom[7] = fop(OP_INCF, 1'b1, 7'h21);
		mem.rom[8] = fop(OP_MOVF, 1'b0, ADDR_PCL);
		mem.rom[9] = fop(OP_COMF, 1'b1, 7'h20);
		go(2);
		repeat (12 * CYC) @(posedge clk);
		#2;
		chk(w, 8'h08);
		chk(status, 8'h00);
		chk(mem.ram[8'h20], 8'haa);
		chk(mem.ram[8'h21], 8'hab);
		chk(mem.ram[8'h04], 8'h3c);
	endtask : file_ops

	task rotate_ops;
		hold();
		mem.rom[0] = lit(OP_MOVLW, 8'h81);
		mem.rom[1] = fop(OP_MOVWF, 1'b1, 7'h22);
		mem.rom[2] = fop(OP_RLF, 1'b1, 7'h22);
		mem.rom[3] = fop(OP_RRF, 1'b0, 7'h22);
		mem.rom[4] = fop(OP_SWAPF, 1'b1, 7'h22);
		mem.rom[5] = fop(OP_DECF, 1'b0, 7'h22);
		mem.rom[6] = lit(OP_XORLW, 8'hff);
		mem.rom[7] = lit(OP_ANDLW, 8'h00);
		go(2);
		repeat (CYC) @(posedge clk);
		step(8'h81, 8'h00);
		step(8'h81, 8'h00);
		step(8'h81, 8'h01);
		step(8'h81, 8'h00);
		step(8'h81, 8'h00);
		step(8'h1f, 8'h00);
		step(8'he0, 8'h00);
		step(8'h00, 8'h04);
		chk(mem.ram[8'h22], 8'h20);
	endtask : rotate_ops

	// Remaining file ops, bank select through status, and a jump by writing the low pc byte
	task bank_pcl_ops;
		hold();
		mem.rom[0]  = lit(OP_MOVLW, 8'h0c);
		mem.rom[1]  = fop(OP_MOVWF, 1'b1, 7'h30);
		mem.rom[2]  = lit(OP_MOVLW, 8'h05);
		mem.rom[3]  = fop(OP_SUBWF, 1'b0, 7'h30);
		mem.rom[4]  = fop(OP_IORWF, 1'b1, 7'h30);
		mem.rom[5]  = fop(OP_ANDWF, 1'b0, 7'h30);
		mem.rom[6]  = fop(OP_XORWF, 1'b0, 7'h30);
		mem.rom[7]  = lit(OP_IORLW, 8'h20);
		mem.rom[8]  = fop(OP_MOVWF, 1'b1, ADDR_STATUS);
		mem.rom[9]  = fop(OP_CLR, 1'b1, 7'h30);
		mem.rom[10] = fop(OP_CLR, 1'b0, 7'h30);
		mem.rom[11] = lit(OP_MOVLW, 8'h10);
		mem.rom[12] = fop(OP_MOVWF, 1'b1, ADDR_PCL);
		mem.rom[13] = lit(OP_MOVLW, 8'h99); // Fetched behind the jump, must be dropped
		mem.rom[16] = fop(OP_MOVF, 1'b0, ADDR_INDF);
		go(2);
		repeat (CYC) @(posedge clk);
		step(8'h0c, 8'h00);
		step(8'h0c, 8'h00);
		step(8'h05, 8'h00);
		step(8'h07, 8'h03);
		step(8'h07, 8'h03);
		step(8'h07, 8'h03);
		step(8'h08, 8'h03);
		step(8'h28, 8'h03);
		step(8'h28, 8'h28);
		step(8'h28, 8'h2c);
		step(8'h00, 8'h2c);
		step(8'h10, 8'h28);
		step(8'h10, 8'h28);
		step(8'h10, 8'h28);
		step(8'h00, 8'h2c);
		chk(8'(prog_addr), 8'h12);
		chk(mem.ram[8'h30], 8'h0f);
		chk(mem.ram[8'hb0], 8'h00);
	endtask : bank_pcl_ops

	// Branch costs two cycles and the word behind it is dropped
	task branch_timing;
		int n;
		hold();
		mem.rom[0] = jmp(11'h004);
		mem.rom[1] = lit(OP_MOVLW, 8'h11);
		mem.rom[4] = lit(OP_MOVLW, 8'h05);
		mem.rom[5] = lit(OP_MOVLW, 8'h06);
		mem.rom[6] = jmp(11'h006);
		go(2);
		wait_change(n);
		chk(8'(n), 8'(4 * CYC));
		chk(w, 8'h05);
		chk(8'(prog_addr), 8'h06);
		wait_change(n);
		chk(8'(n), 8'(CYC));
		chk(w, 8'h06);
	endtask : branch_timing

	initial
	begin
		arith_flags();
		file_ops();
		rotate_ops();
		bank_pcl_ops();
		branch_timing();
		report_and_stop();
	end
endmodule : testbench
